//--- design/oc_pkg.sv
// Package: register map, field layout and modes of the output compare channel
package oc_pkg;
  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_PRIMARY = 4'h1;
  localparam logic [3:0] ADDR_SECONDARY = 4'h2;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h3;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
  localparam logic [3:0] ADDR_GPIO = 4'h5;
  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam int TSEL_BIT = 3;
  localparam int FAULT_BIT = 4;
  localparam int IDLE_BIT = 13;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_WMASK = 16'h200F;
  // ----------------------------------------
  // Interrupt status bits
  // ----------------------------------------
  localparam int IRQ_W = 2;
  localparam int IRQ_PIN = 0;
  localparam int IRQ_FAULT = 1;
  // ----------------------------------------
  // Modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_SET_HIGH = 3'b001,
    MODE_SET_LOW = 3'b010,
    MODE_TOGGLE = 3'b011,
    MODE_ONE_PULSE = 3'b100,
    MODE_PULSES = 3'b101,
    MODE_PWM = 3'b110,
    MODE_PWM_FAULT = 3'b111
  } mode_e;
  typedef struct packed {
    logic idleStop;
    logic timerSel;
    mode_e mode;
  } ctrl_s;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;
endpackage

//--- design/oc_sync.sv
// Two flip-flop synchroniser for one level
module oc_sync (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic din,
  output logic dout
);
  logic stage1;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

//--- design/oc_edge.sv
// Rising and falling edge detector, outputs decoded from a registered previous sample
module oc_edge (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sig,
  output logic rise,
  output logic fall
);
  logic prev;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prev <= 1'b0;
    end else begin
      prev <= sig;
    end
  end
  assign rise = sig & ~prev;
  assign fall = ~sig & prev;
endmodule

//--- design/output_compare_channel.sv
// Output compare channel: compare engine, register slave and interrupt
// Functional notes
// - Timer select bit picks second timer
// - Match against compare registers changes pin
// - Mode 111 PWM, fault input, fault interrupt
// - Mode 110 PWM, fault ignored, no interrupt
// - Mode 101 continuous pulses, falling-edge interrupt
// - Mode 100 one delayed pulse, falling interrupt
// - Mode 011 toggles, interrupt on both edges
// - Mode 010 starts high, match drives low
// - Mode 001 starts low, match drives high
// - Mode 000 disabled, pin from port logic
// - Fault status bit set, hardware-cleared only
// - Idle-stop bit halts channel in Idle; in 111 a fault still drives pin low and interrupts
// - Mode field is control bits 2-0
module output_compare_channel #(
  parameter int TMR_W = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [oc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [oc_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [oc_pkg::DATA_W-1:0] regRdata,
  input wire logic [TMR_W-1:0] firstTimer,
  input wire logic [TMR_W-1:0] secondTimer,
  input wire logic firstTimerRoll,
  input wire logic secondTimerRoll,
  input wire logic cpuIdle,
  input wire logic faultInput,
  input wire logic gpioLevel,
  output logic comparePin,
  output logic irq
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  oc_pkg::ctrl_s ctrl;
  oc_pkg::bus_req_s req;
  logic [TMR_W-1:0] primaryCompare;
  logic [TMR_W-1:0] secondaryCompare;
  logic [TMR_W-1:0] activeDuty;
  logic [oc_pkg::IRQ_W-1:0] irqStatus;
  logic [oc_pkg::IRQ_W-1:0] irqMask;
  logic faultStatus;
  logic pinLevel;
  logic pulseArmed;
  logic faultSync;
  logic faultRise;
  logic faultFall;
  logic pinRise;
  logic pinFall;
  logic ctrlWrite;
  logic [TMR_W-1:0] timerValue;
  logic timerRoll;
  logic running;
  logic matchPrimary;
  logic matchSecondary;
  logic matchDuty;
  logic isPwm;
  logic pinEvent;
  logic faultEvent;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Mode field of a control word
  function automatic oc_pkg::mode_e decodeMode(input logic [oc_pkg::DATA_W-1:0] word);
    return oc_pkg::mode_e'(word[oc_pkg::MODE_LSB +: oc_pkg::MODE_W]);
  endfunction

  // Operands passed in so continuous assigns see every change
  function automatic logic hitsCount(
    input logic live,
    input logic [TMR_W-1:0] count,
    input logic [TMR_W-1:0] cmpValue
  );
    return live && (count == cmpValue);
  endfunction

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
  assign ctrlWrite = req.wr && (req.addr == oc_pkg::ADDR_CONTROL);

  // ----------------------------------------
  // Time base and matches
  // ----------------------------------------
  assign timerValue = ctrl.timerSel ? secondTimer : firstTimer;
  assign timerRoll = ctrl.timerSel ? secondTimerRoll : firstTimerRoll;
  assign running = !(ctrl.idleStop && cpuIdle);
  assign matchPrimary = hitsCount(running, timerValue, primaryCompare);
  assign matchSecondary = hitsCount(running, timerValue, secondaryCompare);
  assign matchDuty = hitsCount(running, timerValue, activeDuty);
  assign isPwm = (ctrl.mode == oc_pkg::MODE_PWM) || (ctrl.mode == oc_pkg::MODE_PWM_FAULT);

  // ----------------------------------------
  // Fault synchroniser and edge detectors
  // ----------------------------------------
  // Fault pin is asynchronous to mclk
  oc_sync faultSyncer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .din(faultInput),
    .dout(faultSync)
  );

  oc_edge faultEdge (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .sig(faultSync),
    .rise(faultRise),
    .fall(faultFall)
  );

  oc_edge pinEdge (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .sig(pinLevel),
    .rise(pinRise),
    .fall(pinFall)
  );

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Writes assumed only with the timer stopped
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl.idleStop <= oc_pkg::CONTROL_RESET[oc_pkg::IDLE_BIT];
      ctrl.timerSel <= oc_pkg::CONTROL_RESET[oc_pkg::TSEL_BIT];
      ctrl.mode <= decodeMode(oc_pkg::CONTROL_RESET);
    end else if (ctrlWrite) begin
      ctrl.idleStop <= req.wdata[oc_pkg::IDLE_BIT];
      ctrl.timerSel <= req.wdata[oc_pkg::TSEL_BIT];
      ctrl.mode <= decodeMode(req.wdata);
    end
  end

  // ----------------------------------------
  // Compare registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      primaryCompare <= '0;
      secondaryCompare <= '0;
    end else if (req.wr) begin
      if (req.addr == oc_pkg::ADDR_PRIMARY) begin
        primaryCompare <= req.wdata[TMR_W-1:0];
      end
      if (req.addr == oc_pkg::ADDR_SECONDARY) begin
        secondaryCompare <= req.wdata[TMR_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Active duty, reloaded at period rollover
  // ----------------------------------------
  // Mid-period updates would glitch the output
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      activeDuty <= '0;
    end else if (ctrlWrite) begin
      activeDuty <= primaryCompare;
    end else if (isPwm && running && timerRoll) begin
      activeDuty <= secondaryCompare;
    end
  end

  // ----------------------------------------
  // Fault status, cleared only by hardware
  // ----------------------------------------
  // Set by a fault in 111; cleared when mode leaves 111 or fault releases at period
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      faultStatus <= 1'b0;
    end else if (ctrl.mode == oc_pkg::MODE_PWM_FAULT && !faultSync && running) begin
      faultStatus <= 1'b1;
    end else if (ctrl.mode != oc_pkg::MODE_PWM_FAULT) begin
      faultStatus <= 1'b0;
    end else if (timerRoll && faultSync) begin
      faultStatus <= 1'b0;
    end
  end

  // ----------------------------------------
  // Output pin engine
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pinLevel <= 1'b0;
      pulseArmed <= 1'b0;
    end else if (ctrlWrite) begin
      pulseArmed <= 1'b1;
      // Entry levels take effect on the write itself
      unique case (decodeMode(req.wdata))
        oc_pkg::MODE_OFF: pinLevel <= pinLevel;
        oc_pkg::MODE_SET_LOW: pinLevel <= 1'b1;
        oc_pkg::MODE_TOGGLE: pinLevel <= pinLevel;
        oc_pkg::MODE_PWM, oc_pkg::MODE_PWM_FAULT: begin
          pinLevel <= (primaryCompare != '0);
        end
        oc_pkg::MODE_SET_HIGH, oc_pkg::MODE_ONE_PULSE, oc_pkg::MODE_PULSES: begin
          pinLevel <= 1'b0;
        end
      endcase
    end else begin
      unique case (ctrl.mode)
        oc_pkg::MODE_OFF: pinLevel <= pinLevel;
        oc_pkg::MODE_SET_HIGH: begin
          if (matchPrimary && pulseArmed) begin
            pinLevel <= 1'b1;
            pulseArmed <= 1'b0;
          end
        end
        oc_pkg::MODE_SET_LOW: begin
          if (matchPrimary && pulseArmed) begin
            pinLevel <= 1'b0;
            pulseArmed <= 1'b0;
          end
        end
        oc_pkg::MODE_TOGGLE: begin
          if (matchPrimary) begin
            pinLevel <= ~pinLevel;
          end
        end
        oc_pkg::MODE_ONE_PULSE, oc_pkg::MODE_PULSES: begin
          if (matchPrimary && pulseArmed) begin
            pinLevel <= 1'b1;
          end else if (matchSecondary && pinLevel) begin
            pinLevel <= 1'b0;
            // Single pulse disarms; continuous mode stays armed
            pulseArmed <= (ctrl.mode == oc_pkg::MODE_PULSES);
          end
        end
        oc_pkg::MODE_PWM, oc_pkg::MODE_PWM_FAULT: begin
          if (ctrl.mode == oc_pkg::MODE_PWM_FAULT && (faultStatus || !faultSync)) begin
            pinLevel <= 1'b0;
          end else if (running && timerRoll) begin
            pinLevel <= (secondaryCompare != '0);
          end else if (matchDuty) begin
            pinLevel <= 1'b0;
          end
        end
      endcase
    end
  end

  assign comparePin = (ctrl.mode == oc_pkg::MODE_OFF) ? gpioLevel : pinLevel;

  // ----------------------------------------
  // Interrupt events
  // ----------------------------------------
  always_comb begin
    pinEvent = 1'b0;
    unique case (ctrl.mode)
      oc_pkg::MODE_OFF: pinEvent = 1'b0;
      oc_pkg::MODE_SET_HIGH: pinEvent = pinRise;
      oc_pkg::MODE_SET_LOW: pinEvent = pinFall;
      oc_pkg::MODE_TOGGLE: pinEvent = pinRise | pinFall;
      oc_pkg::MODE_ONE_PULSE: pinEvent = pinFall;
      oc_pkg::MODE_PULSES: pinEvent = pinFall;
      oc_pkg::MODE_PWM: pinEvent = 1'b0;
      oc_pkg::MODE_PWM_FAULT: pinEvent = 1'b0;
    endcase
  end
  // Fault pin asserts low
  assign faultEvent = (ctrl.mode == oc_pkg::MODE_PWM_FAULT) && faultFall;

  // ----------------------------------------
  // Write tracking and interrupt status
  // ----------------------------------------
  // Edges caused by the mode write itself are suppressed
  logic ctrlWriteDly;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrlWriteDly <= 1'b0;
    end else begin
      ctrlWriteDly <= ctrlWrite;
    end
  end

  // Set wins over write-one-to-clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irqStatus <= '0;
    end else begin
      for (int i = 0; i < oc_pkg::IRQ_W; i++) begin
        if (req.wr && req.addr == oc_pkg::ADDR_IRQ_STATUS && req.wdata[i]) begin
          irqStatus[i] <= 1'b0;
        end
      end
      if (pinEvent && !ctrlWriteDly) begin
        irqStatus[oc_pkg::IRQ_PIN] <= 1'b1;
      end
      if (faultEvent) begin
        irqStatus[oc_pkg::IRQ_FAULT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irqMask <= '0;
    end else if (req.wr && req.addr == oc_pkg::ADDR_IRQ_MASK) begin
      irqMask <= req.wdata[oc_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irqStatus & irqMask);

  // ----------------------------------------
  // Read data, one cycle after strobe
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      regRdata <= '0;
    end else if (req.rd) begin
      regRdata <= '0;
      unique case (req.addr)
        oc_pkg::ADDR_CONTROL: begin
          regRdata[oc_pkg::IDLE_BIT] <= ctrl.idleStop;
          regRdata[oc_pkg::FAULT_BIT] <= faultStatus;
          regRdata[oc_pkg::TSEL_BIT] <= ctrl.timerSel;
          regRdata[oc_pkg::MODE_LSB +: oc_pkg::MODE_W] <= ctrl.mode;
        end
        oc_pkg::ADDR_PRIMARY: regRdata[TMR_W-1:0] <= primaryCompare;
        oc_pkg::ADDR_SECONDARY: regRdata[TMR_W-1:0] <= secondaryCompare;
        oc_pkg::ADDR_IRQ_STATUS: regRdata[oc_pkg::IRQ_W-1:0] <= irqStatus;
        oc_pkg::ADDR_IRQ_MASK: regRdata[oc_pkg::IRQ_W-1:0] <= irqMask;
        oc_pkg::ADDR_GPIO: regRdata[0] <= comparePin;
        default: regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end
endmodule

//--- tb/output_compare_channel_asserts.sv
// Port checker for the output compare channel
module oc_chk #(
  parameter int TMR_W = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdata,
  input wire logic [TMR_W-1:0] firstTimer,
  input wire logic [TMR_W-1:0] secondTimer,
  input wire logic cpuIdle,
  input wire logic faultInput,
  input wire logic gpioLevel,
  input wire logic comparePin
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Shadow of the written control and primary compare values
  // ----------------------------------------
  logic [2:0] md;
  logic ts;
  logic idl;
  logic [TMR_W-1:0] pri;
  wire cw = regWr && regAddr == 4'h0;
  wire [TMR_W-1:0] tm = ts ? secondTimer : firstTimer;
  // A control write this cycle wins, so it is left out
  wire hit = tm == pri && !(idl && cpuIdle) && !cw;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      md <= 3'h0;
      ts <= 1'b0;
      idl <= 1'b0;
    end else if (cw) begin
      md <= regWdata[2:0];
      ts <= regWdata[3];
      idl <= regWdata[13];
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pri <= '0;
    end else if (regWr && regAddr == 4'h1) begin
      pri <= regWdata[TMR_W-1:0];
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ctl_read: assert property ($past(regRd && regAddr == 4'h0) |->
    regRdata[2:0] == $past(md) && regRdata[3] == $past(ts) && regRdata[13] == $past(idl))
    else $error("control read back differs");
  a_off_gpio: assert property (md == 3'h0 |-> comparePin == gpioLevel)
    else $error("disabled pin not port level");
  a_init_low: assert property (cw && regWdata[2:0] inside {3'h1, 3'h4, 3'h5}
    |=> !comparePin) else $error("pin not low after mode write");
  a_init_high: assert property (cw && regWdata[2:0] == 3'h2 |=> comparePin)
    else $error("pin not high after mode write");
  a_pwm_init: assert property (cw && regWdata[2:1] == 2'h3
    |=> comparePin == (pri != '0)) else $error("pwm start level wrong");
  a_keep_level: assert property (cw && regWdata[2:0] == 3'h3 && md != 3'h0 && tm != pri
    |=> $stable(comparePin)) else $error("toggle entry changed pin");
  a_set_high: assert property (md == 3'h1 && hit |=> comparePin)
    else $error("match did not raise pin");
  a_toggle_hit: assert property (md == 3'h3 && hit |=> comparePin != $past(comparePin))
    else $error("match did not toggle pin");
  a_idle_halt: assert property (idl && cpuIdle && md inside {[3'h1:3'h5]} && !cw
    |=> $stable(comparePin)) else $error("pin moved while halted");
  a_fault_low: assert property ((md == 3'h7 && !faultInput) [*5] |-> !comparePin)
    else $error("fault did not force pin low");
  c_toggle: cover property (md == 3'h3 && hit);
  c_fault: cover property (md == 3'h7 && !faultInput);
  c_idle: cover property (idl && cpuIdle && md == 3'h1);
endmodule
bind output_compare_channel oc_chk #(.TMR_W(TMR_W)) chk_u (.mclk, .sys_rst, .regAddr,
  .regWdata, .regWr, .regRd, .regRdata, .firstTimer, .secondTimer, .cpuIdle, .faultInput,
  .gpioLevel, .comparePin);

//--- tb/oc_far_end.sv
// Far-side model: load on the compare pin and source of the fault line
module oc_far_end (
  input wire logic mclk,
  input wire logic comparePin,
  input wire logic tripReq,
  output logic faultN,
  output logic [7:0] pinEdges
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lastPin = 1'b0;
  initial pinEdges = 8'h00;
  // Fault line has a pull-up, so an idle source reads high
  assign faultN = !tripReq;
  always @(posedge mclk) begin
    lastPin <= comparePin;
    if (comparePin !== lastPin) begin
      pinEdges <= pinEdges + 8'h01;
    end
  end
endmodule

//--- tb/output_compare_channel_tb_top.sv
// Testbench for the output compare channel
module output_compare_channel_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdata;
  logic [15:0] tmA = 16'h0000;
  logic [15:0] tmB = 16'h0000;
  logic rollA = 1'b0;
  logic rollB = 1'b0;
  logic run = 1'b0;
  logic cpuIdle = 1'b0;
  logic trip = 1'b0;
  logic gpioLevel = 1'b0;
  logic faultN, comparePin, irq, ex;
  logic [7:0] edges, e0;
  logic [15:0] rd;
  logic [2:0] md [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
  int num_errors = 0;
  int checks_done = 0;
  int i, n;
  output_compare_channel dut_u (.mclk, .sys_rst, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .firstTimer(tmA), .secondTimer(tmB), .firstTimerRoll(rollA),
    .secondTimerRoll(rollB), .cpuIdle, .faultInput(faultN), .gpioLevel, .comparePin, .irq);
  oc_far_end far_u (.mclk, .comparePin, .tripReq(trip), .faultN, .pinEdges(edges));
  always #25 mclk = !mclk;
  // Short timer periods keep each match within a few dozen cycles
  always @(posedge mclk) begin
    tmA <= (!run || tmA == 16'h000F) ? 16'h0000 : tmA + 16'h0001;
    tmB <= (!run || tmB == 16'h001F) ? 16'h0000 : tmB + 16'h0001;
    rollA <= run && tmA == 16'h000F;
    rollB <= run && tmB == 16'h001F;
  end
  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(posedge mclk);
    chk(regRdata, e);
  endtask
  // Timers are stopped around every control write
  task automatic setCtl(input logic [15:0] d);
    run <= 1'b0;
    @(posedge mclk);
    wr(4'h0, d);
    run <= 1'b1;
  endtask
  task automatic waitIrq();
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    if (irq !== 1'b1) begin
      chk(16'h0000, 16'h0001);
      final_report();
    end
  endtask
  task automatic waitTm(input logic [15:0] v);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (tmB !== v && n < 100);
    if (tmB !== v) begin
      chk(16'h0000, 16'h0001);
      final_report();
    end
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rchk(4'h0, 16'h0000);
    rchk(4'h9, 16'h0000);
    wr(4'h0, 16'hFFF0);
    rchk(4'h0, 16'h2000);
    wr(4'h0, 16'h0000);
    gpioLevel <= 1'b1;
    @(posedge mclk);
    chk({15'h0, comparePin}, 16'h0001);
    rchk(4'h5, 16'h0001);
    wr(4'h1, 16'h0014);
    wr(4'h2, 16'h0019);
    wr(4'h4, 16'h0001);
    rchk(4'h1, 16'h0014);
    rchk(4'h2, 16'h0019);
    rchk(4'h4, 16'h0001);
    $display("test registers done");
    setCtl(16'h0001);
    repeat (40) @(posedge mclk);
    chk({14'h0000, comparePin, irq}, 16'h0000);
    for (i = 0; i < 5; i++) begin
      ex = (md[i] == 3'h2) ? 1'b1 : (md[i] == 3'h3) ? comparePin : 1'b0;
      setCtl({12'h001, 1'b1, md[i]});
      chk({15'h0, comparePin}, {15'h0, ex});
      waitIrq();
      ex = (md[i] == 3'h1) ? 1'b1 : (md[i] == 3'h3) ? !ex : 1'b0;
      chk({15'h0, comparePin}, {15'h0, ex});
      rchk(4'h3, 16'h0001);
      wr(4'h3, 16'h0001);
      if (md[i] == 3'h5) begin
        waitIrq();
        wr(4'h3, 16'h0001);
      end
      chk({15'h0, irq}, 16'h0000);
    end
    $display("test modes done");
    cpuIdle <= 1'b1;
    setCtl(16'h2009);
    e0 = edges;
    repeat (70) @(posedge mclk);
    chk({14'h0000, comparePin, irq}, 16'h0000);
    chk({8'h00, edges}, {8'h00, e0});
    cpuIdle <= 1'b0;
    waitIrq();
    chk({15'h0, comparePin}, 16'h0001);
    wr(4'h3, 16'h0001);
    $display("test idle done");
    wr(4'h2, 16'h0008);
    setCtl(16'h000E);
    chk({15'h0, comparePin}, 16'h0001);
    waitTm(16'h001F);
    waitTm(16'h0004);
    chk({15'h0, comparePin}, 16'h0001);
    waitTm(16'h000C);
    chk({15'h0, comparePin}, 16'h0000);
    rchk(4'h3, 16'h0000);
    $display("test pwm done");
    wr(4'h4, 16'h0002);
    setCtl(16'h000F);
    trip <= 1'b1;
    waitIrq();
    chk({15'h0, comparePin}, 16'h0000);
    rchk(4'h0, 16'h001F);
    rchk(4'h3, 16'h0002);
    trip <= 1'b0;
    setCtl(16'h0000);
    rchk(4'h0, 16'h0000);
    wr(4'h3, 16'h0002);
    chk({15'h0, irq}, 16'h0000);
    $display("test fault done");
    final_report();
  end
endmodule
